// file: acfm_clip_chan.sv
// Purpose: Per-channel clip counter and flag
// Assumes: Period strobe and full-duty level come from the PWM monitor on the i_mclk clock
// Notes:   Flag sets when the run of full-duty periods reaches the threshold
`timescale 1ns/1ps
`default_nettype none
module acfm_clip_chan
  import acfm_pkg::*;
#(
  parameter int THR_W = ACFM_THR_W
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  input  wire logic             i_enable,
  input  wire logic             i_latch,
  input  wire logic             i_clear,
  input  wire logic             i_period,
  input  wire logic             i_full_duty,
  input  wire logic [THR_W-1:0] i_threshold,
  output logic                  o_clip,
  output logic                  o_flag
);

  logic [THR_W-1:0] run_q;
  logic [THR_W-1:0] run_d;
  logic             flag_q;
  logic             flag_d;
  logic             at_max;
  logic             reached;

  assign at_max  = &run_q;
  // Run count reaches threshold on a full-duty period
  assign reached = i_enable && i_period && i_full_duty
                   && ({1'b0, run_q} + {{THR_W{1'b0}}, 1'b1}) >= {1'b0, i_threshold};
  assign run_d   = !i_enable ? '0 :
                   !i_period ? run_q :
                   !i_full_duty ? '0 :
                   at_max ? run_q : run_q + 1'b1;
  assign o_clip  = i_enable && (run_q >= i_threshold) && (i_threshold != '0 || i_full_duty);

  // Latched flag holds until clear; set wins over clear
  assign flag_d  = reached ? 1'b1 :
                   i_latch ? (flag_q && !i_clear) :
                   o_clip;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_q  <= '0;
      flag_q <= 1'b0;
    end else begin
      run_q  <= run_d;
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule : acfm_clip_chan
`default_nettype wire

// file: acfm_pkg.sv
// Purpose: Constants and carrier types for the amplifier clip/fault register bank
// Assumes: 8-bit register port with 8-bit addresses
// Notes:   Offsets and reset values match the register map
package acfm_pkg;

  localparam int                  ACFM_AW = 8;
  localparam int                  ACFM_DW = 8;
  localparam int                  ACFM_THR_W = 8;

  localparam logic [ACFM_AW-1:0]  ACFM_ADR_DIAG_LO  = 8'h1e;
  localparam logic [ACFM_AW-1:0]  ACFM_ADR_DIAG_HI  = 8'h1d;
  localparam logic [ACFM_AW-1:0]  ACFM_ADR_FAULT    = 8'h21;
  localparam logic [ACFM_AW-1:0]  ACFM_ADR_CLIPCTL  = 8'h22;
  localparam logic [ACFM_AW-1:0]  ACFM_ADR_CLIPTHR  = 8'h23;
  localparam logic [ACFM_AW-1:0]  ACFM_ADR_CLIPFLG  = 8'h24;
  localparam logic [ACFM_AW-1:0]  ACFM_ADR_ILIM     = 8'h25;
  localparam logic [ACFM_AW-1:0]  ACFM_ADR_MISC4    = 8'h26;

  localparam logic [ACFM_DW-1:0]  ACFM_RST_FAULT    = 8'h00;
  localparam logic [ACFM_DW-1:0]  ACFM_RST_CLIPCTL  = 8'h01;
  localparam logic [ACFM_DW-1:0]  ACFM_RST_CLIPTHR  = 8'h14;
  localparam logic [ACFM_DW-1:0]  ACFM_RST_MISC4    = 8'h40;
  localparam logic [ACFM_DW-1:0]  ACFM_ZERO         = 8'h00;

  // Field positions
  localparam int                  ACFM_B_CLRFLT     = 7;
  localparam int                  ACFM_B_PFLIP      = 6;
  localparam int                  ACFM_B_OTAUTO     = 3;
  localparam int                  ACFM_B_CLIPEN     = 0;
  localparam int                  ACFM_B_NOLATCH    = 1;
  localparam int                  ACFM_B_ROUTE      = 2;
  localparam int                  ACFM_B_BCKINV     = 3;
  localparam int                  ACFM_HPF_HI       = 2;
  // Writable masks: fault bits 7,6,5,4,3; clip ctl bits 2..0; misc4 all
  localparam logic [ACFM_DW-1:0]  ACFM_WM_FAULT     = 8'hf8;
  localparam logic [ACFM_DW-1:0]  ACFM_WM_CLIPCTL   = 8'h07;

  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [ACFM_AW-1:0] addr;
    logic [ACFM_DW-1:0] wdata;
  } acfm_req_t;

  typedef struct packed {
    logic       parallel_bridge_source_flip;
    logic       thermal_shutdown_auto_restart;
    logic       bit_clock_phase_invert;
    logic [2:0] highpass_cutoff_select;
  } acfm_cfg_t;

endpackage : acfm_pkg

// file: acfm_regs.sv
// Purpose: Clip, fault and miscellaneous control register bank of a two-channel amplifier
// Assumes: Register port is the documented control port on the same clock as i_mclk
// Notes:   Pin-sourced status inputs pass three-flop synchronisers
`timescale 1ns/1ps
`default_nettype none
module acfm_regs
  import acfm_pkg::*;
#(
  parameter int NCH = 2
) (
  input  wire logic               i_mclk,
  input  wire logic               i_rstn,
  input  wire acfm_req_t          i_req,
  output logic [ACFM_DW-1:0]      o_rdata,
  output logic                    o_ack,
  input  wire logic               i_clip_mask,
  input  wire logic [NCH-1:0]     i_pwm_period,
  input  wire logic [NCH-1:0]     i_pwm_full_duty,
  input  wire logic [NCH-1:0]     i_current_limiting,
  input  wire logic               i_thermal_shutdown,
  input  wire logic [15:0]        i_ac_diag_second_result,
  output logic                    o_warn_n,
  output logic                    o_fault_clear,
  output logic                    o_thermal_shutdown_hold,
  output acfm_cfg_t               o_cfg
);

  logic [ACFM_DW-1:0] fault_q;
  logic [ACFM_DW-1:0] clipctl_q;
  logic [ACFM_DW-1:0] clipthr_q;
  logic [ACFM_DW-1:0] misc4_q;
  logic [ACFM_DW-1:0] rdata_q;
  logic               clear_q;
  logic               ack_q;
  logic               ot_hold_q;
  logic               ot_hold_d;
  logic               warn_q;
  logic [NCH-1:0]     ilim_s1_q;
  logic [NCH-1:0]     ilim_s2_q;
  logic [NCH-1:0]     ilim_s3_q;
  logic [NCH-1:0]     ilim_q;
  logic [2:0]         ot_sync_q;
  logic               ot_q;
  logic [15:0]        diag_q;

  logic               wr_fault;
  logic               wr_clipctl;
  logic               wr_clipthr;
  logic               wr_misc4;
  logic               clip_enable;
  logic               clip_latch;
  logic               route_both;
  logic [NCH-1:0]     clip_flag;
  logic [ACFM_DW-1:0] rdata_d;
  logic [ACFM_DW-1:0] flag_word;
  logic [ACFM_DW-1:0] ilim_word;
  logic               warn_d;

  assign wr_fault    = i_req.wr && (i_req.addr == ACFM_ADR_FAULT);
  assign wr_clipctl  = i_req.wr && (i_req.addr == ACFM_ADR_CLIPCTL);
  assign wr_clipthr  = i_req.wr && (i_req.addr == ACFM_ADR_CLIPTHR);
  assign wr_misc4    = i_req.wr && (i_req.addr == ACFM_ADR_MISC4);

  assign clip_enable = clipctl_q[ACFM_B_CLIPEN];
  assign clip_latch  = !clipctl_q[ACFM_B_NOLATCH];
  assign route_both  = !clipctl_q[ACFM_B_ROUTE];

  // Control registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      fault_q   <= ACFM_RST_FAULT;
      clipctl_q <= ACFM_RST_CLIPCTL;
      clipthr_q <= ACFM_RST_CLIPTHR;
      misc4_q   <= ACFM_RST_MISC4;
      clear_q   <= 1'b0;
    end else begin
      clear_q <= wr_fault && i_req.wdata[ACFM_B_CLRFLT];
      if (wr_fault) begin
        // Strobe bit self-clears so it reads back zero
        fault_q <= i_req.wdata & ACFM_WM_FAULT & ~(ACFM_DW'(1) << ACFM_B_CLRFLT);
      end
      if (wr_clipctl) begin
        clipctl_q <= i_req.wdata & ACFM_WM_CLIPCTL;
      end
      if (wr_clipthr) begin
        clipthr_q <= i_req.wdata;
      end
      if (wr_misc4) begin
        misc4_q <= i_req.wdata;
      end
    end
  end

  // Pin-sourced status: three flops, change accepted when stages two and three agree
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ilim_s1_q <= '0;
      ilim_s2_q <= '0;
      ilim_s3_q <= '0;
      ilim_q    <= '0;
      ot_sync_q <= '0;
      ot_q      <= 1'b0;
    end else begin
      ilim_s1_q <= i_current_limiting;
      ilim_s2_q <= ilim_s1_q;
      ilim_s3_q <= ilim_s2_q;
      ilim_q    <= (ilim_s2_q & ilim_s3_q) | (ilim_q & (ilim_s2_q | ilim_s3_q));
      ot_sync_q <= {ot_sync_q[1:0], i_thermal_shutdown};
      if (ot_sync_q[1] == ot_sync_q[2]) begin
        ot_q <= ot_sync_q[2];
      end
    end
  end

  // Thermal shutdown hold: latched until clear, or follows condition in auto mode
  assign ot_hold_d = ot_q ? 1'b1 :
                     fault_q[ACFM_B_OTAUTO] ? 1'b0 :
                     (ot_hold_q && !clear_q);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ot_hold_q <= 1'b0;
      warn_q    <= 1'b0;
      diag_q    <= '0;
    end else begin
      ot_hold_q <= ot_hold_d;
      warn_q    <= warn_d;
      diag_q    <= i_ac_diag_second_result;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      acfm_clip_chan #(
        .THR_W(ACFM_THR_W)
      ) u_chan (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_enable   (clip_enable),
        .i_latch    (clip_latch),
        .i_clear    (clear_q),
        .i_period   (i_pwm_period[ch]),
        .i_full_duty(i_pwm_full_duty[ch]),
        .i_threshold(clipthr_q),
        .o_clip     (),
        .o_flag     (clip_flag[ch])
      );
    end
  endgenerate

  // Warning pin: any channel flag, gated by route and mask
  assign warn_d = route_both && !i_clip_mask && (|clip_flag);

  assign flag_word = ACFM_DW'(clip_flag);
  assign ilim_word = ACFM_DW'(ilim_q);

  // Read mux; unmapped addresses read zero
  assign rdata_d = (i_req.addr == ACFM_ADR_DIAG_LO) ? diag_q[7:0] :
                   (i_req.addr == ACFM_ADR_DIAG_HI) ? diag_q[15:8] :
                   (i_req.addr == ACFM_ADR_FAULT)   ? fault_q :
                   (i_req.addr == ACFM_ADR_CLIPCTL) ? clipctl_q :
                   (i_req.addr == ACFM_ADR_CLIPTHR) ? clipthr_q :
                   (i_req.addr == ACFM_ADR_CLIPFLG) ? flag_word :
                   (i_req.addr == ACFM_ADR_ILIM)    ? ilim_word :
                   (i_req.addr == ACFM_ADR_MISC4)   ? misc4_q : ACFM_ZERO;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= ACFM_ZERO;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= i_req.wr || i_req.rd;
      if (i_req.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign o_rdata                              = rdata_q;
  assign o_ack                                = ack_q;
  assign o_warn_n                             = !warn_q;
  assign o_fault_clear                        = clear_q;
  assign o_thermal_shutdown_hold              = ot_hold_q;
  assign o_cfg.parallel_bridge_source_flip    = fault_q[ACFM_B_PFLIP];
  assign o_cfg.thermal_shutdown_auto_restart  = fault_q[ACFM_B_OTAUTO];
  assign o_cfg.bit_clock_phase_invert         = misc4_q[ACFM_B_BCKINV];
  assign o_cfg.highpass_cutoff_select         = misc4_q[ACFM_HPF_HI:0];

endmodule : acfm_regs
`default_nettype wire

// file: acfm_regs_assertions.sv
// Purpose: Port checks for acfm_regs
// Assumes: One clock, async active-low reset
// Notes:   Attached by bind below
`timescale 1ns/1ps
`default_nettype none
module acfm_regs_assertions
  import acfm_pkg::*;
(
  input wire logic               i_mclk,
  input wire logic               i_rstn,
  input wire acfm_req_t          i_req,
  input wire logic [ACFM_DW-1:0] o_rdata,
  input wire logic               o_ack,
  input wire logic               i_clip_mask,
  input wire logic               o_warn_n,
  input wire logic               o_fault_clear,
  input wire acfm_cfg_t          o_cfg
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  wire logic [7:0] ad = i_req.addr;
  wire logic       wf = i_req.wr && ad == ACFM_ADR_FAULT;
  a_clear_pulse: assert property (wf && i_req.wdata[7] |=> o_fault_clear)
    else $error("fault clear pulse missing");
  a_clear_cause: assert property (o_fault_clear |-> $past(wf && i_req.wdata[7]))
    else $error("fault clear without write");
  a_fault_cfg_write: assert property (wf |=> o_cfg.parallel_bridge_source_flip == $past(i_req.wdata[6])
    && o_cfg.thermal_shutdown_auto_restart == $past(i_req.wdata[3])) else $error("fault cfg wrong");
  a_misc4_cfg_write: assert property (i_req.wr && ad == ACFM_ADR_MISC4 |=>
    o_cfg[3:0] == $past(i_req.wdata[3:0])) else $error("misc4 cfg wrong");
  a_fault_rd_zero: assert property (i_req.rd && ad == ACFM_ADR_FAULT |=> o_ack && o_rdata[7] == 0
    && o_rdata[2:0] == 0) else $error("fault readback bits");
  a_clipctl_rsvd: assert property (i_req.rd && ad == ACFM_ADR_CLIPCTL |=> o_rdata[7:3] == 0)
    else $error("clip ctl reserved bits");
  a_flag_rsvd: assert property (i_req.rd && ad == ACFM_ADR_CLIPFLG |=> o_rdata[7:2] == 0)
    else $error("clip flag reserved bits");
  a_ilim_rsvd: assert property (i_req.rd && ad == ACFM_ADR_ILIM |=> o_rdata[7:2] == 0)
    else $error("ilim reserved bits");
  a_mask_quiet: assert property (i_clip_mask [*2] |-> o_warn_n)
    else $error("warn while masked");
  a_ack_timing: assert property (o_ack == $past(i_req.wr || i_req.rd))
    else $error("ack not one cycle after request");
  cover property ($fell(o_warn_n));
  cover property (o_fault_clear);
  cover property (i_req.rd && ad == ACFM_ADR_CLIPFLG);
endmodule : acfm_regs_assertions
bind acfm_regs acfm_regs_assertions u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req),
  .o_rdata(o_rdata), .o_ack(o_ack), .i_clip_mask(i_clip_mask), .o_warn_n(o_warn_n),
  .o_fault_clear(o_fault_clear), .o_cfg(o_cfg));
`default_nettype wire

// file: acfm_regs_tb.sv
// Purpose: Self-checking bench for acfm_regs
// Assumes: Inputs change at falling edge
// Notes:   Register model kept in array m
`timescale 1ns/1ps
`default_nettype none
module acfm_regs_tb
  import acfm_pkg::*;
;
  logic i_mclk, i_rstn, ack, mask, ts, wn, fc, tsh, fcs;
  acfm_req_t rq;
  acfm_cfg_t cfg;
  logic [7:0] rdata;
  logic [1:0] per, full, ilim;
  logic [15:0] diag;
  logic [7:0] m [256];
  logic [7:0] al [10] = '{8'h1e, 8'h1d, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h00, 8'h30};
  int mismatches, check_count;
  acfm_regs u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(rq), .o_rdata(rdata), .o_ack(ack),
    .i_clip_mask(mask), .i_pwm_period(per), .i_pwm_full_duty(full), .i_current_limiting(ilim),
    .i_thermal_shutdown(ts), .i_ac_diag_second_result(diag), .o_warn_n(wn), .o_fault_clear(fc),
    .o_thermal_shutdown_hold(tsh), .o_cfg(cfg));
  initial begin
    i_mclk = 0;
    forever #4 i_mclk = ~i_mclk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    rq = '{w, !w, a, d};
    cyc(1);
    fcs = fc;
    rq = '0;
    k = 0;
    while (ack !== 1'b1) begin
      if (++k > 4) begin
        mismatches++;
        summarize();
      end
      cyc(1);
    end
    cyc(1);
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
    chk(fcs, d[7] && a == ACFM_ADR_FAULT);
    case (a)
      ACFM_ADR_FAULT: m[a] = d & 8'h78;
      ACFM_ADR_CLIPCTL: m[a] = d & ACFM_WM_CLIPCTL;
      ACFM_ADR_CLIPTHR, ACFM_ADR_MISC4: m[a] = d;
      default: ;
    endcase
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(rdata, e);
  endtask : rd
  task automatic pls(input logic [1:0] p, input logic [1:0] f, input int n);
    full = f;
    repeat (n) begin
      per = p;
      cyc(1);
      per = 0;
      cyc(1);
    end
    cyc(2);
  endtask : pls
  task automatic cfgchk;
    chk(8'(cfg), {2'b00, m[8'h21][6], m[8'h21][3], m[8'h26][3:0]});
  endtask : cfgchk
  initial begin
    i_rstn = 0;
    rq = '0;
    {mask, ts, per, full, ilim, diag} = '0;
    foreach (m[i]) m[i] = 8'h00;
    m[8'h22] = ACFM_RST_CLIPCTL;
    m[8'h23] = ACFM_RST_CLIPTHR;
    m[8'h26] = ACFM_RST_MISC4;
    void'($urandom(32'h5110));
    cyc(5);
    i_rstn = 1;
    foreach (al[i]) rd(al[i], m[al[i]]);
    cfgchk();
    chk(wn, 1);
    $display("reset values done");
    repeat (4) begin
      foreach (al[i]) wr(al[i], 8'($urandom));
      foreach (al[i]) rd(al[i], m[al[i]]);
      cfgchk();
    end
    for (int c = 0; c < 8; c++) begin
      wr(ACFM_ADR_MISC4, 8'(c * 9));
      cfgchk();
    end
    $display("register access done");
    repeat (4) begin
      diag = 16'($urandom);
      ilim = 2'($urandom);
      cyc(6);
      rd(ACFM_ADR_DIAG_LO, diag[7:0]);
      rd(ACFM_ADR_DIAG_HI, diag[15:8]);
      rd(ACFM_ADR_ILIM, {6'h00, ilim});
    end
    $display("status done");
    wr(ACFM_ADR_FAULT, 8'h80);
    wr(ACFM_ADR_CLIPTHR, 8'h03);
    wr(ACFM_ADR_CLIPCTL, 8'h01);
    pls(3, 3, 2);
    rd(ACFM_ADR_CLIPFLG, 8'h00);
    pls(3, 3, 1);
    rd(ACFM_ADR_CLIPFLG, 8'h03);
    chk(wn, 0);
    pls(3, 0, 1);
    rd(ACFM_ADR_CLIPFLG, 8'h03);
    chk(wn, 0);
    mask = 1;
    cyc(3);
    chk(wn, 1);
    mask = 0;
    wr(ACFM_ADR_FAULT, 8'h80);
    cyc(2);
    rd(ACFM_ADR_CLIPFLG, 8'h00);
    chk(wn, 1);
    wr(ACFM_ADR_CLIPCTL, 8'h03);
    pls(1, 1, 3);
    rd(ACFM_ADR_CLIPFLG, 8'h01);
    chk(wn, 0);
    pls(1, 0, 1);
    rd(ACFM_ADR_CLIPFLG, 8'h00);
    chk(wn, 1);
    pls(2, 2, 3);
    rd(ACFM_ADR_CLIPFLG, 8'h02);
    wr(ACFM_ADR_CLIPCTL, 8'h02);
    pls(3, 3, 4);
    rd(ACFM_ADR_CLIPFLG, 8'h00);
    $display("clip done");
    wr(ACFM_ADR_FAULT, 8'h00);
    ts = 1;
    cyc(8);
    chk(tsh, 1);
    ts = 0;
    cyc(8);
    chk(tsh, 1);
    wr(ACFM_ADR_FAULT, 8'h88);
    cyc(4);
    chk(tsh, 0);
    ts = 1;
    cyc(8);
    chk(tsh, 1);
    ts = 0;
    cyc(8);
    chk(tsh, 0);
    $display("thermal done");
    summarize();
  end
endmodule : acfm_regs_tb
`default_nettype wire
